//--- verilog/bcd_top.sv
`default_nettype none
`include "bcd_cfg.svh"

// Function
// - Decode media opcodes; read, write, capacity, verify, start/stop mandatory.
// - Accept inquiry, mode select, mode sense, unit-ready; others optional.
// - Removal prevention only for removable; buffer write mandatory on fixed media.
// - Immediate format answers after validation, otherwise after completion.
// - No periodic progress reports unless progress requested.
// - Progress unit is elapsed time or percentage per unit-select.
// - Steps of five, or one when fine step selected.
// - Progress report is check condition, not ready, 04h/04h.
// - Report information carries increments elapsed since format start.
// - Success is unit attention 38h/04h with new-media event 02h.
// - Format failure is media error 31h/01h.
// - During format, new commands get the progress report instead.
// - Read block: big-endian address bytes 2-5, length 7-8.
// - Read starts at the address and moves length contiguous blocks.
// - Read returns the latest written contents of each block.
// - Zero-length read moves nothing and completes good.
// - Address past capacity ends illegal request 21h/00h unless the length is zero.
module bcd_top import bcd_pkg::*; #(
	parameter int unsigned SEC_CYCLES = `BCD_STEP_TIME_S * `BCD_MCLK_HZ
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Configuration
	input wire bcd_cfg_t cfg,
	input wire logic [31:0] capacity,
	// Command blocks in
	input wire bcd_cdb_t cdb,
	input wire logic cdb_valid,
	output logic cdb_ready,
	// Status out
	output bcd_resp_t resp,
	output logic resp_valid,
	input wire logic resp_ready,
	// Commands handled elsewhere
	output bcd_cdb_t fwd_cdb,
	output logic fwd_valid,
	// Block reads to the medium
	output logic blk_req_valid,
	output logic [31:0] blk_req_addr,
	input wire logic blk_req_ready,
	// Medium format control
	output logic fmt_start,
	output logic fmt_busy,
	input wire logic [6:0] fmt_pct,
	input wire logic fmt_done,
	input wire logic fmt_fail
);

	////////////////////////////////////////////////////////////////////////
	// Decode

	bcd_state_t state_q, state_d;
	bcd_resp_t resp_q, resp_d;
	bcd_cdb_t fwd_cdb_q;
	logic resp_valid_q, resp_load;
	logic fwd_valid_q, fwd_go;
	logic fmt_start_q, fmt_go;
	logic prog_q, pct_q, fine_q;
	logic end_pend_q, fail_pend_q;
	logic [31:0] secs_q, next_rep_q;
	logic rd_start, rd_done, sec_tick, rep_fire;

	wire [7:0] op = cdb[0];
	wire accept = cdb_valid && cdb_ready;
	wire ctl_ok = bcd_ctl_byte(cdb) == 8'h00;
	wire supp = bcd_supported(op, cfg);
	wire is_fmt = op == `BCD_OP_FORMAT;
	wire is_read = op == `BCD_OP_READ10;
	wire [7:0] fmt_flags = cdb[1];
	wire [31:0] rd_lba = {cdb[2], cdb[3], cdb[4], cdb[5]};
	wire [15:0] rd_len = {cdb[7], cdb[8]};
	wire [32:0] rd_end = {1'b0, rd_lba} + {17'h0, rd_len};
	wire rd_oob = rd_end > {1'b0, capacity};
	wire in_fmt = state_q == BCD_FMT;
	wire [31:0] fmt_count = pct_q ? {25'h0, fmt_pct} : secs_q;
	wire [31:0] step = fine_q ? `BCD_STEP_FINE : `BCD_STEP_COARSE;
	wire [31:0] first_step = fmt_flags[`BCD_FMT_STEP] ? `BCD_STEP_FINE : `BCD_STEP_COARSE;
	wire rep_due = prog_q && fmt_count >= next_rep_q;
	wire end_now = end_pend_q || fmt_done || fmt_fail;
	wire fail_now = fail_pend_q || fmt_fail;

	// Fixed status words
	wire bcd_resp_t r_good = bcd_mk(`BCD_ST_GOOD, `BCD_SK_NONE, 8'h00, 8'h00, 32'h0);
	wire bcd_resp_t r_prog = bcd_mk(`BCD_ST_CHECK, `BCD_SK_NOT_READY, `BCD_ASC_NOT_READY,
		`BCD_ASCQ_FMT_BUSY, fmt_count);
	wire bcd_resp_t r_fmt_ok = bcd_mk(`BCD_ST_CHECK, `BCD_SK_UNIT_ATTN, `BCD_ASC_EVENT,
		`BCD_ASCQ_MEDIA_EVENT, {24'h0, `BCD_EVT_NEW_MEDIA});
	wire bcd_resp_t r_fmt_bad = bcd_mk(`BCD_ST_CHECK, `BCD_SK_MEDIUM_ERR, `BCD_ASC_FMT_FAIL,
		`BCD_ASCQ_FMT_FAIL, 32'h0);
	wire bcd_resp_t r_range = bcd_mk(`BCD_ST_CHECK, `BCD_SK_ILLEGAL, `BCD_ASC_LBA_RANGE,
		`BCD_ASCQ_ZERO, 32'h0);
	wire bcd_resp_t r_opcode = bcd_mk(`BCD_ST_CHECK, `BCD_SK_ILLEGAL, `BCD_ASC_BAD_OPCODE,
		`BCD_ASCQ_ZERO, 32'h0);
	wire bcd_resp_t r_field = bcd_mk(`BCD_ST_CHECK, `BCD_SK_ILLEGAL, `BCD_ASC_BAD_FIELD,
		`BCD_ASCQ_ZERO, 32'h0);

	// Only one status may be outstanding; a finished format blocks new input
	assign cdb_ready = !resp_valid_q && (state_q == BCD_IDLE || (in_fmt && !end_now));

	////////////////////////////////////////////////////////////////////////
	// Command sequencer

	always_comb begin
		state_d = state_q;
		resp_d = resp_q;
		resp_load = 1'b0;
		rd_start = 1'b0;
		fmt_go = 1'b0;
		fwd_go = 1'b0;
		rep_fire = 1'b0;
		case (state_q)
			BCD_IDLE: begin
				if (accept) begin
					resp_load = 1'b1;
					resp_d = r_good;
					if (!ctl_ok) begin
						resp_d = r_field;
					end else if (!supp) begin
						resp_d = r_opcode;
					end else if (is_fmt) begin
						fmt_go = 1'b1;
						state_d = BCD_FMT;
						resp_load = fmt_flags[`BCD_FMT_IMMED];
					end else if (is_read) begin
						if (rd_len == 16'h0) begin
							resp_d = r_good;
						end else if (rd_oob) begin
							resp_d = r_range;
						end else begin
							resp_load = 1'b0;
							rd_start = 1'b1;
							state_d = BCD_READ;
						end
					end else begin
						resp_load = 1'b0;
						fwd_go = 1'b1;
					end
				end
			end
			BCD_READ: begin
				if (rd_done) begin
					resp_load = 1'b1;
					resp_d = r_good;
					state_d = BCD_IDLE;
				end
			end
			BCD_FMT: begin
				if (!resp_valid_q) begin
					if (end_now) begin
						resp_load = 1'b1;
						resp_d = fail_now ? r_fmt_bad : r_fmt_ok;
						state_d = BCD_IDLE;
					end else if (accept) begin
						resp_load = 1'b1;
						resp_d = r_prog;
					end else if (rep_due) begin
						resp_load = 1'b1;
						resp_d = r_prog;
						rep_fire = 1'b1;
					end
				end
			end
			default: state_d = BCD_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= BCD_IDLE;
			resp_q <= '0;
			resp_valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (resp_load) begin
				resp_q <= resp_d;
			end
			resp_valid_q <= resp_load || (resp_valid_q && !resp_ready);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fwd_cdb_q <= '0;
			fwd_valid_q <= 1'b0;
			fmt_start_q <= 1'b0;
		end else begin
			fwd_valid_q <= fwd_go;
			fmt_start_q <= fmt_go;
			if (fwd_go) begin
				fwd_cdb_q <= cdb;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Format progress

	// Done may land while a report is still waiting; keep it until sent
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			end_pend_q <= 1'b0;
			fail_pend_q <= 1'b0;
		end else if (in_fmt && (fmt_done || fmt_fail)) begin
			end_pend_q <= 1'b1;
			fail_pend_q <= fail_pend_q || fmt_fail;
		end else if (state_d != BCD_FMT) begin
			end_pend_q <= 1'b0;
			fail_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prog_q <= 1'b0;
			pct_q <= 1'b0;
			fine_q <= 1'b0;
			secs_q <= 32'h0;
			next_rep_q <= 32'h0;
		end else if (fmt_go) begin
			prog_q <= fmt_flags[`BCD_FMT_PROGRESS];
			pct_q <= fmt_flags[`BCD_FMT_PCT];
			fine_q <= fmt_flags[`BCD_FMT_STEP];
			secs_q <= 32'h0;
			next_rep_q <= first_step;
		end else begin
			if (in_fmt && sec_tick) begin
				secs_q <= secs_q + 32'h1;
			end
			if (rep_fire) begin
				next_rep_q <= next_rep_q + step;
			end
		end
	end

	bcd_tick #(
		.CYC(SEC_CYCLES)
	) u_tick (
		.mclk(mclk),
		.nrst(nrst),
		.clr(fmt_go),
		.en(in_fmt),
		.tick(sec_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Read transfer

	// Data come straight from the medium, so the latest write is seen
	bcd_rdseq #(
		.AW(32),
		.LW(16)
	) u_rdseq (
		.mclk(mclk),
		.nrst(nrst),
		.start(rd_start),
		.lba(rd_lba),
		.len(rd_len),
		.req_valid(blk_req_valid),
		.req_addr(blk_req_addr),
		.req_ready(blk_req_ready),
		.done(rd_done)
	);

	assign resp = resp_q;
	assign resp_valid = resp_valid_q;
	assign fwd_cdb = fwd_cdb_q;
	assign fwd_valid = fwd_valid_q;
	assign fmt_start = fmt_start_q;
	assign fmt_busy = in_fmt;

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic hs_seen_q;
	logic [31:0] last_addr_q;
	wire blk_hs = blk_req_valid && blk_req_ready;
	logic [7:0] fmt_flags_d1;
	wire cmd_fmt_ok = ctl_ok && supp && is_fmt;
	wire cmd_rd_ok = ctl_ok && supp && is_read;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			fmt_flags_d1 <= 8'h00;
		end else begin
			fmt_flags_d1 <= fmt_flags;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hs_seen_q <= 1'b0;
			last_addr_q <= 32'h0;
		end else if (rd_start) begin
			hs_seen_q <= 1'b0;
		end else if (blk_hs) begin
			hs_seen_q <= 1'b1;
			last_addr_q <= blk_req_addr;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_bad_opcode: assert property (
		state_q == BCD_IDLE && accept && ctl_ok && !supp
		|=> resp_valid && resp.asc == `BCD_ASC_BAD_OPCODE)
		else $error("unsupported opcode not rejected");
	a_immed_status: assert property (
		state_q == BCD_IDLE && accept && cmd_fmt_ok
		|=> resp_valid == fmt_flags_d1[`BCD_FMT_IMMED])
		else $error("format status timing wrong");
	a_no_report: assert property (rep_fire |-> prog_q)
		else $error("progress report without request");
	a_report_code: assert property (
		resp_valid && resp.skey == `BCD_SK_NOT_READY
		|-> resp.status == `BCD_ST_CHECK && resp.asc == 8'h04 && resp.ascq == 8'h04)
		else $error("bad progress sense");
	a_fmt_success: assert property (
		in_fmt && !resp_valid && end_now && !fail_now
		|=> resp.skey == `BCD_SK_UNIT_ATTN && resp.asc == 8'h38 && resp.info[7:0] == 8'h02)
		else $error("bad format success status");
	a_fmt_failure: assert property (
		in_fmt && !resp_valid && fail_now
		|=> resp.skey == `BCD_SK_MEDIUM_ERR && resp.asc == 8'h31 && resp.ascq == 8'h01)
		else $error("bad format failure status");
	a_busy_answer: assert property (
		in_fmt && accept |=> !fwd_valid && !fmt_start && resp.skey == `BCD_SK_NOT_READY)
		else $error("command executed during format");
	a_zero_len: assert property (
		state_q == BCD_IDLE && accept && cmd_rd_ok && rd_len == 16'h0
		|=> resp_valid && resp.status == `BCD_ST_GOOD ##1 !blk_req_valid)
		else $error("zero length read misbehaved");
	a_lba_range: assert property (
		state_q == BCD_IDLE && accept && cmd_rd_ok && rd_len != 16'h0 && rd_oob
		|=> resp.asc == `BCD_ASC_LBA_RANGE && !blk_req_valid)
		else $error("out of range read not rejected");
	a_read_ascend: assert property (
		blk_req_valid && hs_seen_q |-> blk_req_addr == last_addr_q + 32'h1)
		else $error("read blocks not ascending");

	c_fmt_done: cover property (in_fmt && end_now && !fail_now ##1 state_q == BCD_IDLE);
	c_read_multi: cover property (blk_hs ##[1:4] blk_hs ##[1:4] rd_done);
	c_report: cover property (rep_fire);
	c_busy_cmd: cover property (in_fmt && accept);


endmodule // bcd_top

`default_nettype wire

//--- common/bcd_cfg.svh
`ifndef BCD_CFG_SVH
`define BCD_CFG_SVH

// Opcodes
`define BCD_OP_TUR 8'h00
`define BCD_OP_REQSENSE 8'h03
`define BCD_OP_FORMAT 8'h04
`define BCD_OP_INQUIRY 8'h12
`define BCD_OP_MSEL 8'h15
`define BCD_OP_RESERVE 8'h16
`define BCD_OP_RELEASE 8'h17
`define BCD_OP_MSENSE 8'h1a
`define BCD_OP_STARTSTOP 8'h1b
`define BCD_OP_PREVENT 8'h1e
`define BCD_OP_CAPACITY 8'h25
`define BCD_OP_READ10 8'h28
`define BCD_OP_WRITE10 8'h2a
`define BCD_OP_VERIFY10 8'h2f
`define BCD_OP_SYNC 8'h35
`define BCD_OP_WBUF 8'h3b
`define BCD_OP_PRIN 8'h5e
`define BCD_OP_PROUT 8'h5f

// Status, sense keys, codes
`define BCD_ST_GOOD 8'h00
`define BCD_ST_CHECK 8'h02
`define BCD_SK_NONE 8'h00
`define BCD_SK_NOT_READY 8'h02
`define BCD_SK_MEDIUM_ERR 8'h03
`define BCD_SK_ILLEGAL 8'h05
`define BCD_SK_UNIT_ATTN 8'h06
`define BCD_ASC_NOT_READY 8'h04
`define BCD_ASCQ_FMT_BUSY 8'h04
`define BCD_ASC_EVENT 8'h38
`define BCD_ASCQ_MEDIA_EVENT 8'h04
`define BCD_EVT_NEW_MEDIA 8'h02
`define BCD_ASC_FMT_FAIL 8'h31
`define BCD_ASCQ_FMT_FAIL 8'h01
`define BCD_ASC_LBA_RANGE 8'h21
`define BCD_ASC_BAD_OPCODE 8'h20
`define BCD_ASC_BAD_FIELD 8'h24
`define BCD_ASCQ_ZERO 8'h00

// Format flag positions in byte 1
`define BCD_FMT_IMMED 3
`define BCD_FMT_PROGRESS 2
`define BCD_FMT_PCT 1
`define BCD_FMT_STEP 0

// Progress steps and timing
`define BCD_STEP_COARSE 32'h5
`define BCD_STEP_FINE 32'h1
`define BCD_STEP_TIME_S 1
`define BCD_MCLK_HZ 40000000

`endif

//--- common/bcd_pkg.sv
`default_nettype none
`include "bcd_cfg.svh"

package bcd_pkg;

	typedef logic [0:9][7:0] bcd_cdb_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] skey;
		logic [7:0] asc;
		logic [7:0] ascq;
		logic [31:0] info;
	} bcd_resp_t;

	typedef struct packed {
		logic removable;
		logic format_supported_flag;
		logic opt_sync;
		logic opt_persist;
		logic opt_sense;
		logic opt_reserve;
		logic opt_wbuf;
	} bcd_cfg_t;

	typedef enum logic [1:0] {BCD_IDLE, BCD_READ, BCD_FMT} bcd_state_t;

	function automatic bcd_resp_t bcd_mk(input logic [7:0] st, input logic [7:0] sk,
		input logic [7:0] asc, input logic [7:0] ascq, input logic [31:0] info);
		bcd_resp_t r;
		r.status = st;
		r.skey = sk;
		r.asc = asc;
		r.ascq = ascq;
		r.info = info;
		return r;
	endfunction

	function automatic logic bcd_supported(input logic [7:0] op, input bcd_cfg_t c);
		case (op)
			`BCD_OP_READ10, `BCD_OP_WRITE10, `BCD_OP_CAPACITY, `BCD_OP_VERIFY10,
			`BCD_OP_STARTSTOP, `BCD_OP_INQUIRY, `BCD_OP_MSEL, `BCD_OP_MSENSE,
			`BCD_OP_TUR: return 1'b1;
			`BCD_OP_FORMAT: return c.format_supported_flag;
			`BCD_OP_SYNC: return c.opt_sync;
			`BCD_OP_REQSENSE: return c.opt_sense;
			`BCD_OP_RESERVE, `BCD_OP_RELEASE: return c.opt_reserve;
			`BCD_OP_PRIN, `BCD_OP_PROUT: return c.opt_persist;
			`BCD_OP_PREVENT: return c.removable;
			`BCD_OP_WBUF: return !c.removable || c.opt_wbuf;
			default: return 1'b0;
		endcase
	endfunction

	// Six-byte blocks are group 0, ten-byte blocks groups 1 and 2
	function automatic logic [7:0] bcd_ctl_byte(input bcd_cdb_t c);
		return (c[0][7:5] == 3'h0) ? c[5] : c[9];
	endfunction

endpackage

`default_nettype wire

//--- verilog/bcd_tick.sv
`default_nettype none

module bcd_tick import bcd_pkg::*; #(
	parameter int unsigned CYC = 40000000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control
	input wire logic clr,
	input wire logic en,
	// One-cycle enable pulse
	output logic tick
);

	logic [31:0] cnt_q;
	logic tick_q;
	wire wrap = cnt_q == CYC[31:0] - 32'h1;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= (clr || !en || wrap) ? 32'h0 : cnt_q + 32'h1;
			tick_q <= en && !clr && wrap;
		end
	end

	assign tick = tick_q;

endmodule // bcd_tick

`default_nettype wire

//--- verilog/bcd_rdseq.sv
`default_nettype none

module bcd_rdseq import bcd_pkg::*; #(
	parameter int unsigned AW = 32,
	parameter int unsigned LW = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Start of a run
	input wire logic start,
	input wire logic [AW-1:0] lba,
	input wire logic [LW-1:0] len,
	// Block requests to the medium
	output logic req_valid,
	output logic [AW-1:0] req_addr,
	input wire logic req_ready,
	// End of run
	output logic done
);

	logic busy_q, done_q;
	logic [AW-1:0] addr_q;
	logic [LW-1:0] left_q;
	wire hs = busy_q && req_ready;
	wire last = left_q == {{(LW-1){1'b0}}, 1'b1};

	// Ascending contiguous blocks from the first address
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			addr_q <= '0;
			left_q <= '0;
		end else begin
			done_q <= hs && last;
			if (start) begin
				busy_q <= 1'b1;
				addr_q <= lba;
				left_q <= len;
			end else if (hs) begin
				busy_q <= !last;
				addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
				left_q <= left_q - {{(LW-1){1'b0}}, 1'b1};
			end
		end
	end

	assign req_valid = busy_q;
	assign req_addr = addr_q;
	assign done = done_q;

endmodule // bcd_rdseq

`default_nettype wire

//--- testbench/bcd_medium.sv
`default_nettype none

module bcd_medium import bcd_pkg::*; #(
	parameter int unsigned STEP = 8,
	parameter int unsigned LAST = 810
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Behaviour select
	input wire logic slow,
	input wire logic fail_mode,
	// Block requests
	output logic blk_req_ready,
	// Format control
	input wire logic fmt_start,
	output logic [6:0] fmt_pct,
	output logic fmt_done,
	output logic fmt_fail
);
	int seed = 32'h0d7b;
	int t;
	logic run;

	// Moves on the falling edge, clear of the sampling edge
	always @(negedge mclk or negedge nrst) begin
		if (!nrst) begin
			run <= 1'b0;
			t <= 0;
			fmt_pct <= 7'h00;
			fmt_done <= 1'b0;
			fmt_fail <= 1'b0;
			blk_req_ready <= 1'b0;
		end else begin
			fmt_done <= 1'b0;
			fmt_fail <= 1'b0;
			// Slow medium stalls at random
			blk_req_ready <= slow ? 1'($random(seed)) : 1'b1;
			if (fmt_start) begin
				run <= 1'b1;
				t <= 0;
				fmt_pct <= 7'h00;
			end else if (run) begin
				t <= t + 1;
				if (t % STEP == STEP - 1 && fmt_pct < 7'h64)
					fmt_pct <= fmt_pct + 7'h01;
				if (t == LAST) begin
					run <= 1'b0;
					fmt_fail <= fail_mode;
					fmt_done <= !fail_mode;
				end
			end
		end
	end
endmodule // bcd_medium

`default_nettype wire

//--- testbench/test_block_command_decoder.sv
`default_nettype none

module test_block_command_decoder import bcd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 0, nrst = 0, cdb_valid = 0, resp_ready = 1, slow = 0, fail_mode = 0, rr_rand = 0;
	logic cdb_ready, resp_valid, fwd_valid, blk_req_valid, blk_req_ready, fmt_start, fmt_busy, fmt_done, fmt_fail;
	bcd_cfg_t cfg = '0;
	logic [31:0] capacity = 32'h100, blk_req_addr;
	bcd_cdb_t cdb = '0, fwd_cdb;
	bcd_resp_t resp;
	logic [6:0] fmt_pct;
	int seed = 32'h0d7b;
	int bad_count = 0, comparisons = 0;
	bcd_resp_t rq[$];
	logic [31:0] bq[$];

	always #12.5 mclk = ~mclk;

	bcd_top #(.SEC_CYCLES(20)) u_dut (.mclk(mclk), .nrst(nrst), .cfg(cfg), .capacity(capacity), .cdb(cdb),
		.cdb_valid(cdb_valid), .cdb_ready(cdb_ready), .resp(resp), .resp_valid(resp_valid),
		.resp_ready(resp_ready), .fwd_cdb(fwd_cdb), .fwd_valid(fwd_valid), .blk_req_valid(blk_req_valid),
		.blk_req_addr(blk_req_addr), .blk_req_ready(blk_req_ready), .fmt_start(fmt_start),
		.fmt_busy(fmt_busy), .fmt_pct(fmt_pct), .fmt_done(fmt_done), .fmt_fail(fmt_fail));

	bcd_medium u_medium (.mclk(mclk), .nrst(nrst), .slow(slow), .fail_mode(fail_mode),
		.blk_req_ready(blk_req_ready), .fmt_start(fmt_start), .fmt_pct(fmt_pct),
		.fmt_done(fmt_done), .fmt_fail(fmt_fail));

	always @(negedge mclk) resp_ready <= rr_rand ? 1'($random(seed)) : 1'b1;

	////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [79:0] seen, input logic [79:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	function automatic bcd_resp_t mk(input logic [7:0] st, sk, asc, ascq, input logic [31:0] info);
		mk = '{st, sk, asc, ascq, info};
	endfunction

	function automatic logic sup(input logic [7:0] op, input bcd_cfg_t c);
		case (op)
			8'h28, 8'h2a, 8'h25, 8'h2f, 8'h1b, 8'h12, 8'h15, 8'h1a, 8'h00: sup = 1'b1;
			8'h04: sup = c.format_supported_flag;
			8'h35: sup = c.opt_sync;
			8'h03: sup = c.opt_sense;
			8'h16, 8'h17: sup = c.opt_reserve;
			8'h5e, 8'h5f: sup = c.opt_persist;
			8'h1e: sup = c.removable;
			8'h3b: sup = !c.removable || c.opt_wbuf;
			default: sup = 1'b0;
		endcase
	endfunction

	// Oldest note is compared against each handshake
	always @(posedge mclk) begin
		if (nrst && resp_valid && resp_ready) begin
			if (rq.size() == 0) chk("resp_extra", 80'(resp), 80'h0);
			else chk("resp", 80'(resp), 80'(rq.pop_front()));
		end
		if (nrst && blk_req_valid && blk_req_ready) begin
			if (bq.size() == 0) chk("blk_extra", 80'(blk_req_addr), 80'h0);
			else chk("blk_req_addr", 80'(blk_req_addr), 80'(bq.pop_front()));
		end
	end

	task automatic drain;
		int n = 0;
		while ((rq.size() != 0 || bq.size() != 0) && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 5000) begin
			chk("wait_bound", 80'h1, 80'h0);
			close_out();
		end
	endtask

	// Control byte always zero unless a refusal is meant
	task automatic send(input bcd_cdb_t c);
		int n = 0;
		@(negedge mclk);
		cdb = c;
		cdb_valid = 1'b1;
		while (cdb_ready !== 1'b1 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		if (n >= 5000) begin
			chk("ready_bound", 80'h1, 80'h0);
			close_out();
		end else begin
			@(negedge mclk);
			cdb_valid = 1'b0;
		end
	endtask

	task automatic rd(input logic [31:0] lba, input logic [15:0] len);
		bcd_cdb_t c;
		logic go;
		c = '0;
		go = 1'b0;
		c[0] = 8'h28;
		{c[2], c[3], c[4], c[5]} = lba;
		{c[7], c[8]} = len;
		if (len == 16'h0) rq.push_back(mk(8'h00, 8'h00, 8'h00, 8'h00, 0));
		else if ({1'b0, lba} + 33'(len) > 33'(capacity)) rq.push_back(mk(8'h02, 8'h05, 8'h21, 8'h00, 0));
		else begin
			go = 1'b1;
			for (int i = 0; i < int'(len); i++) bq.push_back(lba + 32'(i));
			rq.push_back(mk(8'h00, 8'h00, 8'h00, 8'h00, 0));
		end
		send(c);
		// A running read refuses further blocks
		if (go) chk("cdb_ready", 80'(cdb_ready), 80'h0);
		drain();
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		bcd_cdb_t c;
		logic s;
		logic [15:0] len;
		logic [5:0] r;
		int v;
		logic [5:0] rows [5];
		rows = '{6'h0e, 6'h07, 6'h04, 6'h05, 6'h3a};
		repeat (8) @(negedge mclk);
		nrst = 1'b1;
		// Opcode map on fixed, removable and random setups
		for (int k = 0; k < 3; k++) begin
			cfg = (k == 0) ? '0 : (k == 1) ? '1 : bcd_cfg_t'(7'($random(seed)));
			for (int op = 0; op < 256; op++) begin
				if (op == 8'h28 || (op == 8'h04 && cfg.format_supported_flag)) continue;
				c = '0;
				c[0] = op[7:0];
				s = sup(op[7:0], cfg);
				if (!s) rq.push_back(mk(8'h02, 8'h05, 8'h20, 8'h00, 0));
				send(c);
				chk("fwd_valid", 80'(fwd_valid), 80'(s));
				if (s) chk("fwd_cdb", fwd_cdb, c);
				drain();
			end
		end
		// Nonzero control byte, short and long blocks
		c = '0;
		c[5] = 8'h01;
		rq.push_back(mk(8'h02, 8'h05, 8'h24, 8'h00, 0));
		send(c);
		c = '0;
		c[0] = 8'h25;
		c[9] = 8'h80;
		rq.push_back(mk(8'h02, 8'h05, 8'h24, 8'h00, 0));
		send(c);
		drain();
		// Reads with a stalling medium and slow initiator
		slow = 1'b1;
		rr_rand = 1'b1;
		rd(32'h0, 16'h0);
		rd(32'hfc, 16'h4);
		rd(32'hfd, 16'h4);
		rd(32'h0, 16'h100);
		rd(32'h0, 16'h101);
		for (int k = 0; k < 8; k++) begin
			len = 16'(1 + $unsigned($random(seed)) % 8);
			rd(32'($unsigned($random(seed)) % (32'h101 - 32'(len))), len);
		end
		// Formats; first row keeps the coarse step
		slow = 1'b0;
		rr_rand = 1'b0;
		cfg = '1;
		for (int k = 0; k < 5; k++) begin
			r = rows[k];
			fail_mode = r[4];
			c = '0;
			c[0] = 8'h04;
			c[1] = {4'h0, r[3:0]};
			if (r[3]) rq.push_back(mk(8'h00, 8'h00, 8'h00, 8'h00, 0));
			if (r[2])
				for (v = r[0] ? 1 : 5; v <= (r[1] ? 100 : 40); v += (r[0] ? 1 : 5))
					rq.push_back(mk(8'h02, 8'h02, 8'h04, 8'h04, v));
			send(c);
			chk("fmt_busy", 80'(fmt_busy), 80'h1);
			chk("fmt_start", 80'(fmt_start), 80'h1);
			if (r[5]) begin
				len = 16'(fmt_pct);
				v = 0;
				while (fmt_pct === len[6:0] && v < 100) begin
					@(negedge mclk);
					v++;
				end
				rq.push_back(mk(8'h02, 8'h02, 8'h04, 8'h04, 32'(fmt_pct)));
				c = '0;
				send(c);
				chk("fwd_valid", 80'(fwd_valid), 80'h0);
			end
			rq.push_back(r[4] ? mk(8'h02, 8'h03, 8'h31, 8'h01, 0) : mk(8'h02, 8'h06, 8'h38, 8'h04, 2));
			drain();
			chk("fmt_busy", 80'(fmt_busy), 80'h0);
			c = '0;
			c[0] = 8'h1a;
			send(c);
			chk("fwd_valid", 80'(fwd_valid), 80'h1);
			c[0] = 8'h25;
			send(c);
			chk("fwd_valid", 80'(fwd_valid), 80'h1);
		end
		close_out();
	end

	initial begin
		#2500000;
		chk("run_bound", 80'h1, 80'h0);
		close_out();
	end
endmodule // test_block_command_decoder

`default_nettype wire
